// ---- logic/temp_limit_compare.sv ----
// Limit checking of three temperature results against six signed limits,
// plus the partner-port field of the per-port function words.
// Assumes register accesses and measurement results arrive on clk_sys.
`timescale 1ns/10ps

// Behaviour
// - Internal result above internal high limit sets internal flag bit 2.
// - Internal result below internal low limit sets internal flag bit 1.
// - First remote result above its high limit sets its flag bit 2.
// - First remote result below its low limit sets its flag bit 1.
// - Second remote result above its high limit sets its flag bit 2.
// - Second remote result below its low limit sets its flag bit 1.
// - Limits are 12-bit two's complement in bits 11:0, 0.125 C per step.
// - Function word bits 4:0 pick a partner, used only in modes 4, 8, 11.
// - Partner field holds the port address, ports 0 to 4 as 0x02 to 0x06.
// - Each monitor has its own enable bit; disabled means no checks.
module temp_limit_compare #(
   parameter int NUM_PORTS = temp_limit_pkg::NUM_PORTS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register access from the serial front end
   input wire logic [temp_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [temp_limit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [temp_limit_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Measurement results, one done pulse per sensor
   input wire logic [temp_limit_pkg::NUM_SENSORS-1:0] meas_done,
   input wire logic [temp_limit_pkg::TEMP_W-1:0] temp_internal,
   input wire logic [temp_limit_pkg::TEMP_W-1:0] temp_remote1,
   input wire logic [temp_limit_pkg::TEMP_W-1:0] temp_remote2,
   // Port function modes from the mode fields
   input wire logic [NUM_PORTS*temp_limit_pkg::MODE_W-1:0] port_mode,
   // Monitor state
   output logic [temp_limit_pkg::NUM_SENSORS-1:0] monitor_enable_select,
   output logic [temp_limit_pkg::FLAG_W-1:0] internal_temp_flags,
   output logic [temp_limit_pkg::FLAG_W-1:0] remote1_temp_flags,
   output logic [temp_limit_pkg::FLAG_W-1:0] remote2_temp_flags,
   // Partner-port decode
   output logic [NUM_PORTS-1:0] partner_valid,
   output logic [NUM_PORTS*temp_limit_pkg::INDEX_W-1:0] partner_index
);

   if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
      $error("NUM_PORTS must lie between 1 and 16");
   end

   localparam int NS = temp_limit_pkg::NUM_SENSORS;
   localparam int TW = temp_limit_pkg::TEMP_W;
   localparam int DW = temp_limit_pkg::DATA_W;
   localparam int FW = temp_limit_pkg::FLAG_W;
   localparam int IW = temp_limit_pkg::INDEX_W;
   localparam int MW = temp_limit_pkg::MODE_W;

   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] base,
                                    input int offs);
      addr_is = (addr == base + 8'(offs));
   endfunction : addr_is

   function automatic logic partner_mode(input logic [3:0] mode);
      partner_mode = (mode == temp_limit_pkg::MODE_PAIR_A) ||
                     (mode == temp_limit_pkg::MODE_PAIR_B) ||
                     (mode == temp_limit_pkg::MODE_PAIR_C);
   endfunction : partner_mode

   // Reset release through two flops
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   logic [NS-1:0] mon_sel;
   logic [NS-1:0] next_mon_sel;
   logic [TW-1:0] limit [temp_limit_pkg::NUM_LIMITS];
   logic [TW-1:0] next_limit [temp_limit_pkg::NUM_LIMITS];
   logic [TW-1:0] func_word [NUM_PORTS];
   logic [TW-1:0] next_func_word [NUM_PORTS];
   logic [FW-1:0] flags [NS];
   logic [FW-1:0] next_flags [NS];
   logic [DW-1:0] next_rdata;
   logic next_rvalid;
   logic [NUM_PORTS-1:0] next_partner_valid;
   logic [NUM_PORTS*IW-1:0] next_partner_index;
   logic [TW-1:0] temp_in [NS];

   assign temp_in[0] = temp_internal;
   assign temp_in[1] = temp_remote1;
   assign temp_in[2] = temp_remote2;

   always_comb begin
      logic [DW-1:0] rd_word;
      logic [4:0] field;
      rd_word = '0;
      field = '0;
      next_mon_sel = mon_sel;
      next_limit = limit;
      next_func_word = func_word;
      next_flags = flags;
      next_partner_valid = '0;
      next_partner_index = '0;
      next_rvalid = reg_rd;
      next_rdata = reg_rdata;
      // Read mux; unmapped indices read zero
      if (addr_is(reg_addr, temp_limit_pkg::ADDR_MON_SEL, 0)) begin
         rd_word = {13'h0000, mon_sel};
      end
      for (int s = 0; s < NS; s++) begin
         if (addr_is(reg_addr, temp_limit_pkg::ADDR_FLAGS_BASE, s)) begin
            rd_word = {13'h0000, flags[s]};
         end
      end
      for (int l = 0; l < temp_limit_pkg::NUM_LIMITS; l++) begin
         if (addr_is(reg_addr, temp_limit_pkg::ADDR_LIMIT_BASE, l)) begin
            rd_word = {4'h0, limit[l]};
         end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (addr_is(reg_addr, temp_limit_pkg::ADDR_FUNC_BASE, p)) begin
            rd_word = {4'h0, func_word[p]};
         end
      end
      if (reg_rd) begin
         next_rdata = rd_word;
      end
      // Writes; bits above the 12-bit fields are dropped
      if (reg_wr) begin
         if (addr_is(reg_addr, temp_limit_pkg::ADDR_MON_SEL, 0)) begin
            next_mon_sel = reg_wdata[NS-1:0];
         end
         for (int l = 0; l < temp_limit_pkg::NUM_LIMITS; l++) begin
            if (addr_is(reg_addr, temp_limit_pkg::ADDR_LIMIT_BASE, l)) begin
               next_limit[l] = reg_wdata[TW-1:0];
            end
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (addr_is(reg_addr, temp_limit_pkg::ADDR_FUNC_BASE, p)) begin
               next_func_word[p] = reg_wdata[TW-1:0];
            end
         end
      end
      // Flags are sticky until read; a crossing in the read cycle still sets
      for (int s = 0; s < NS; s++) begin
         if (reg_rd && addr_is(reg_addr, temp_limit_pkg::ADDR_FLAGS_BASE, s)) begin
            next_flags[s] = '0;
         end
         if (meas_done[s] && mon_sel[s]) begin
            if ($signed(temp_in[s]) > $signed(limit[2*s])) begin
               next_flags[s][temp_limit_pkg::FLAG_HIGH_BIT] = 1'b1;
            end
            if ($signed(temp_in[s]) < $signed(limit[2*s+1])) begin
               next_flags[s][temp_limit_pkg::FLAG_LOW_BIT] = 1'b1;
            end
         end
      end
      // Out-of-range partner addresses are treated as no partner
      for (int p = 0; p < NUM_PORTS; p++) begin
         field = func_word[p][temp_limit_pkg::PARTNER_MSB:0];
         if (partner_mode(port_mode[p*MW +: MW]) &&
             field >= temp_limit_pkg::PARTNER_FIRST &&
             field <= temp_limit_pkg::PARTNER_LAST) begin
            next_partner_valid[p] = 1'b1;
            next_partner_index[p*IW +: IW] =
               IW'(field - temp_limit_pkg::PARTNER_FIRST);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         mon_sel <= temp_limit_pkg::MON_SEL_RESET;
         for (int l = 0; l < temp_limit_pkg::NUM_LIMITS; l++) begin
            limit[l] <= (l % 2 == 0) ? temp_limit_pkg::HIGH_LIMIT_RESET :
                        temp_limit_pkg::LOW_LIMIT_RESET;
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            func_word[p] <= temp_limit_pkg::FUNC_RESET;
         end
         for (int s = 0; s < NS; s++) begin
            flags[s] <= '0;
         end
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
         partner_valid <= '0;
         partner_index <= '0;
      end else begin
         mon_sel <= next_mon_sel;
         limit <= next_limit;
         func_word <= next_func_word;
         flags <= next_flags;
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
         partner_valid <= next_partner_valid;
         partner_index <= next_partner_index;
      end
   end

   assign monitor_enable_select = mon_sel;
   assign internal_temp_flags = flags[0];
   assign remote1_temp_flags = flags[1];
   assign remote2_temp_flags = flags[2];

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_sync);

   property p_int_high;
      meas_done[0] && mon_sel[0] && ($signed(temp_internal) > $signed(limit[0]))
         |=> internal_temp_flags[2];
   endproperty
   a_int_high: assert property (p_int_high) else $error("internal high flag missed");

   property p_int_low;
      meas_done[0] && mon_sel[0] && ($signed(temp_internal) < $signed(limit[1]))
         |=> internal_temp_flags[1];
   endproperty
   a_int_low: assert property (p_int_low) else $error("internal low flag missed");

   property p_r1_high;
      meas_done[1] && mon_sel[1] && ($signed(temp_remote1) > $signed(limit[2]))
         |=> remote1_temp_flags[2];
   endproperty
   a_r1_high: assert property (p_r1_high) else $error("remote1 high flag missed");

   property p_r1_low;
      meas_done[1] && mon_sel[1] && ($signed(temp_remote1) < $signed(limit[3]))
         |=> remote1_temp_flags[1];
   endproperty
   a_r1_low: assert property (p_r1_low) else $error("remote1 low flag missed");

   property p_r2_high;
      meas_done[2] && mon_sel[2] && ($signed(temp_remote2) > $signed(limit[4]))
         |=> remote2_temp_flags[2];
   endproperty
   a_r2_high: assert property (p_r2_high) else $error("remote2 high flag missed");

   property p_r2_low;
      meas_done[2] && mon_sel[2] && ($signed(temp_remote2) < $signed(limit[5]))
         |=> remote2_temp_flags[1];
   endproperty
   a_r2_low: assert property (p_r2_low) else $error("remote2 low flag missed");

   sequence s_write_limit0;
      reg_wr && !reg_rd && reg_addr == temp_limit_pkg::ADDR_LIMIT_BASE;
   endsequence
   sequence s_read_limit0;
      reg_rd && !reg_wr && reg_addr == temp_limit_pkg::ADDR_LIMIT_BASE;
   endsequence
   property p_limit_store;
      s_write_limit0 ##1 s_read_limit0
         |=> reg_rvalid && reg_rdata == {4'h0, $past(reg_wdata[11:0], 2)};
   endproperty
   a_limit_store: assert property (p_limit_store) else $error("limit readback wrong");

   property p_partner_mode;
      partner_valid[0] |-> $past(partner_mode(port_mode[MW-1:0]));
   endproperty
   a_partner_mode: assert property (p_partner_mode) else $error("partner outside mode");

   property p_partner_code;
      partner_valid[0] |-> 5'(partner_index[IW-1:0]) + 5'h02 == $past(func_word[0][4:0]);
   endproperty
   a_partner_code: assert property (p_partner_code) else $error("partner index wrong");

   property p_monitor_off;
      $rose(internal_temp_flags[2]) |-> $past(meas_done[0] && mon_sel[0]);
   endproperty
   a_monitor_off: assert property (p_monitor_off) else $error("flag set while idle");

   property p_equal_no_flag;
      meas_done[0] && temp_internal == limit[0] && !internal_temp_flags[2]
         |=> !internal_temp_flags[2];
   endproperty
   a_equal_no_flag: assert property (p_equal_no_flag) else $error("equal set flag");

   // The internal high flag drops only through a read of its own register
   property p_flag_sticky;
      $fell(internal_temp_flags[2])
         |-> $past(reg_rd && reg_addr == temp_limit_pkg::ADDR_FLAGS_BASE);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without read");

   sequence s_read_r1_quiet;
      reg_rd && reg_addr == 8'(temp_limit_pkg::ADDR_FLAGS_BASE + 8'h01) && !meas_done[1];
   endsequence
   property p_r1_clear;
      s_read_r1_quiet |=> remote1_temp_flags == 3'h0;
   endproperty
   a_r1_clear: assert property (p_r1_clear) else $error("remote1 flags not cleared");

   property p_partner_off;
      !$past(partner_mode(port_mode[MW-1:0]))
         |-> !partner_valid[0] && partner_index[IW-1:0] == '0;
   endproperty
   a_partner_off: assert property (p_partner_off) else $error("partner in other mode");

endmodule : temp_limit_compare

// ---- logic/temp_limit_pkg.sv ----
// Constants for the temperature limit compare block: register map, field
// positions, reset values and port function decode.
// Assumes a serial front end that turns host frames into word accesses.
package temp_limit_pkg;
   localparam int TEMP_W = 12;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int NUM_SENSORS = 3;
   localparam int NUM_LIMITS = 6;
   localparam int NUM_PORTS = 11;
   localparam int MODE_W = 4;
   localparam int INDEX_W = 3;
   localparam int FLAG_W = 3;
   // Flag field bit positions
   localparam int FLAG_HIGH_BIT = 2;
   localparam int FLAG_LOW_BIT = 1;
   // Register indices, one 16-bit word each
   localparam logic [7:0] ADDR_MON_SEL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS_BASE = 8'h01;
   localparam logic [7:0] ADDR_LIMIT_BASE = 8'h04;
   localparam logic [7:0] ADDR_FUNC_BASE = 8'h10;
   // Limit order: even index high, odd index low; sensor s uses 2s and 2s+1
   localparam logic [11:0] HIGH_LIMIT_RESET = 12'h7FF;
   localparam logic [11:0] LOW_LIMIT_RESET = 12'h800;
   localparam logic [11:0] FUNC_RESET = 12'h000;
   localparam logic [2:0] MON_SEL_RESET = 3'h0;
   // Partner-port field of the function word
   localparam int PARTNER_MSB = 4;
   localparam logic [4:0] PARTNER_FIRST = 5'h02;
   localparam logic [4:0] PARTNER_LAST = 5'h06;
   // Function modes that use the partner port
   localparam logic [3:0] MODE_PAIR_A = 4'h4;
   localparam logic [3:0] MODE_PAIR_B = 4'h8;
   localparam logic [3:0] MODE_PAIR_C = 4'hB;
endpackage : temp_limit_pkg

// ---- tb/temp_limit_host.sv ----
// Host model of the register path: one-cycle word writes and reads.
// Assumes the read answer comes one edge after the read strobe.
`timescale 1ns/10ps
module temp_limit_host (
   // Clock
   input wire logic clk_sys,
   // Register access
   output logic [temp_limit_pkg::ADDR_W-1:0] reg_addr,
   output logic [temp_limit_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [temp_limit_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Released lines flip so a stale copy can never pass for fresh data
   task automatic release_bus();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask : release_bus
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      release_bus();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      release_bus();
      ok = 1'b0;
      d = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(posedge clk_sys);
         end
      end
   endtask : rd
endmodule : temp_limit_host

// ---- tb/test_temp_limit_compare.sv ----
// Self-checking bench for the limit compare block and partner-port decode.
// Assumes the host model drives the register path and the bench the results.
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module test_temp_limit_compare;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [2:0] meas_done = 3'h0;
   logic [11:0] temp = 12'h000;
   logic [43:0] port_mode = 44'h0;
   logic [2:0] mon_sel, flags_int, flags_r1, flags_r2;
   logic [10:0] partner_valid;
   logic [32:0] partner_index;
   logic [8:0] flags_all;
   int miscompares = 0;
   int comparisons = 0;
   assign flags_all = {flags_r2, flags_r1, flags_int};
   always #20 clk_sys = ~clk_sys;
   temp_limit_compare dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .meas_done(meas_done), .temp_internal(temp),
      .temp_remote1(temp), .temp_remote2(temp), .port_mode(port_mode),
      .monitor_enable_select(mon_sel), .internal_temp_flags(flags_int),
      .remote1_temp_flags(flags_r1), .remote2_temp_flags(flags_r2),
      .partner_valid(partner_valid), .partner_index(partner_index));
   temp_limit_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic read_check(input logic [7:0] a, input logic [15:0] exp, input string nm);
      logic [15:0] d;
      bit ok;
      host.rd(a, d, ok);
      if (!ok) begin
         miscompares++;
         give_verdict();
      end
      `CHECK(nm, exp, d)
   endtask : read_check
   // One result pulse; the flag is visible just after the sampling edge
   task automatic meas(input int s, input logic [11:0] t, input logic [8:0] exp);
      @(posedge clk_sys);
      meas_done <= 3'(1 << s);
      temp <= t;
      @(posedge clk_sys);
      meas_done <= 3'h0;
      #1;
      `CHECK("flags", exp, flags_all)
   endtask : meas
   task automatic reset_values();
      `CHECK("flags", 9'h000, flags_all)
      `CHECK("monitor select pin", 3'h0, mon_sel)
      for (int i = 0; i < 6; i++) begin
         read_check(8'(temp_limit_pkg::ADDR_LIMIT_BASE + i), (i % 2) ? 16'h0800 : 16'h07FF,
            "limit");
      end
      read_check(temp_limit_pkg::ADDR_MON_SEL, 16'h0000, "monitor select");
      read_check(temp_limit_pkg::ADDR_FUNC_BASE, 16'h0000, "function word");
      host.wr(8'h0A, 16'h0123);
      read_check(8'h0A, 16'h0000, "unmapped");
      host.wr(temp_limit_pkg::ADDR_LIMIT_BASE, 16'hF123);
      read_check(temp_limit_pkg::ADDR_LIMIT_BASE, 16'h0123, "limit width");
   endtask : reset_values
   task automatic limit_crossings();
      host.wr(temp_limit_pkg::ADDR_MON_SEL, 16'h0007);
      for (int s = 0; s < 3; s++) begin
         // High limit 25 C, low limit -25 C
         host.wr(8'(temp_limit_pkg::ADDR_LIMIT_BASE + 2 * s), 16'h00C8);
         host.wr(8'(temp_limit_pkg::ADDR_LIMIT_BASE + 2 * s + 1), 16'h0F38);
      end
      for (int s = 0; s < 3; s++) begin
         meas(s, 12'h0C8, 9'h000);
         meas(s, 12'hF38, 9'h000);
         meas(s, 12'h0C9, 9'(9'h004 << (3 * s)));
         read_check(8'(temp_limit_pkg::ADDR_FLAGS_BASE + s), 16'h0004, "flag read");
         `CHECK("flags cleared", 9'h000, flags_all)
         // Most negative result: an unsigned compare would also flag high
         meas(s, 12'h800, 9'(9'h002 << (3 * s)));
         read_check(8'(temp_limit_pkg::ADDR_FLAGS_BASE + s), 16'h0002, "flag read");
      end
   endtask : limit_crossings
   task automatic disabled_monitor();
      host.wr(temp_limit_pkg::ADDR_MON_SEL, 16'h0006);
      read_check(temp_limit_pkg::ADDR_MON_SEL, 16'h0006, "monitor select");
      `CHECK("monitor select pin", 3'h6, mon_sel)
      meas(0, 12'h7FF, 9'h000);
      meas(1, 12'h7FF, 9'h020);
      read_check(8'(temp_limit_pkg::ADDR_FLAGS_BASE + 1), 16'h0004, "flag read");
   endtask : disabled_monitor
   task automatic partner_decode();
      logic [3:0] modes [4];
      logic [43:0] pm;
      logic v;
      int p;
      modes = '{temp_limit_pkg::MODE_PAIR_A, temp_limit_pkg::MODE_PAIR_B,
         temp_limit_pkg::MODE_PAIR_C, 4'h5};
      for (int i = 0; i < 4; i++) begin
         for (int f = 1; f < 8; f++) begin
            p = 3 * i;
            pm = 44'h0;
            pm[4 * p +: 4] = modes[i];
            @(posedge clk_sys);
            port_mode <= pm;
            host.wr(8'(temp_limit_pkg::ADDR_FUNC_BASE + p), 16'(f));
            @(posedge clk_sys);
            #1;
            v = (i < 3) && (f >= 2) && (f <= 6);
            `CHECK("partner valid", v, partner_valid[p])
            `CHECK("partner index", v ? 3'(f - 2) : 3'h0, partner_index[3 * p +: 3])
         end
      end
   endtask : partner_decode
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset_values();
      limit_crossings();
      disabled_monitor();
      partner_decode();
      give_verdict();
   end
endmodule : test_temp_limit_compare
